// ---- hdl/tx_lead_timer.v ----
// Transmit lead timer: APB registers, 50 ns tick, transmitter and amplifier enables
//
// Behaviour
// - Timing runs in 50 ns ticks, the 20 MHz system tick, made here from the 50 MHz clock.
// - The symbol period tick count is 9 bits, low byte in its own register, bit 8 at bit 0 of the high register.
// - One symbol lasts the programmed tick count, 0x140 ticks (16 us) after reset.
// - The transmitter lead tick count is 9 bits, bits 6:0 at high register bits 7:1, bits 8:7 at third register bits 1:0.
// - Transmitter enable rises ahead of packet start by its tick lead, default 0x028 ticks.
// - The amplifier lead tick count is 9 bits, low byte in the first register, bit 8 at bit 0 of the second.
// - Amplifier enable rises ahead of packet start by its tick lead, default 0x029 ticks.
// - The amplifier symbol lead at bits 4:1 of the second register counts whole symbol periods.
// - The transmitter symbol lead counts symbol periods, minimum 0x1 (a zero lead is accepted here, not guarded), default 0x2, 0x6 advised.
`timescale 1ns/10ps
`include "tx_lead_defines.vh"
module tx_lead_timer #(
    parameter ADDR_W = 8,
    parameter TICK_W = 9,
    parameter SYM_W = 4,
    parameter CNT_W = 14
) (
    input wire clk,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire tx_request,
    input wire tx_done,
    output wire tx_enable,
    output wire amp_enable,
    output reg packet_start,
    output reg lead_busy
);
    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_LEAD = 2'd1;
    localparam [1:0] ST_TRANSMIT = 2'd2;

    // Tick accumulator steps, in 10 ns units
    localparam integer STEP_I = `CLK_PERIOD_NS / `PHASE_UNIT_NS;
    localparam integer MOD_I = `TICK_NS / `PHASE_UNIT_NS;
    localparam [3:0] PHASE_STEP = STEP_I[3:0];
    localparam [3:0] PHASE_MOD = MOD_I[3:0];

    // Configuration fields
    reg [TICK_W-1:0] symbol_tick_count;
    reg [TICK_W-1:0] tx_lead_ticks;
    reg [SYM_W-1:0] tx_lead_symbols;
    reg [TICK_W-1:0] amp_lead_ticks;
    reg [SYM_W-1:0] amp_lead_symbols;
    reg buffer_path_enable;

    // Sequencer
    reg [1:0] state;
    reg [1:0] next_state;
    reg [CNT_W-1:0] remaining;
    reg [CNT_W-1:0] next_remaining;
    reg next_packet_start;
    reg [3:0] phase;
    reg [3:0] next_phase;
    reg tick;
    reg next_tick;

    // Both lead totals share one down counter
    wire [CNT_W-1:0] tx_lead_total;
    wire [CNT_W-1:0] amp_lead_total;
    wire [CNT_W-1:0] max_lead;
    wire active;

    // Bus decode
    // Only aligned words in the mapped range answer without error
    wire setup;
    wire wr;
    wire [5:0] idx;
    wire aligned;
    reg mapped;
    reg [7:0] read_byte;

    // Setup cycle and completing write
    assign setup = psel & ~penable;
    assign wr = psel & penable & pready & pwrite;
    assign idx = paddr[7:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign active = (state != ST_IDLE);
    // Longer lead loads the counter so both enables compare against it
    assign max_lead = (tx_lead_total > amp_lead_total) ? tx_lead_total : amp_lead_total;

    // Fractional tick: 2.5 clocks of 20 ns per 50 ns tick on average
    always @* begin
        // Ticks land two or three clocks apart; enables jitter by one clock
        next_phase = phase + PHASE_STEP;
        next_tick = 1'b0;
        if (next_phase >= PHASE_MOD) begin
            next_phase = next_phase - PHASE_MOD;
            next_tick = 1'b1;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase <= 4'h0;
            tick <= 1'b0;
        end else begin
            // Registered tick keeps the counter off the adder path
            phase <= next_phase;
            tick <= next_tick;
        end
    end

    // Read mux; reserved bits read zero
    always @* begin
        mapped = 1'b1;
        read_byte = 8'h00;
        case (idx)
            `IDX_SYMBOL_TICK_LOW: begin
                read_byte = symbol_tick_count[7:0];
            end
            `IDX_SYMBOL_TICK_HIGH: begin
                read_byte = {tx_lead_ticks[6:0], symbol_tick_count[8]};
            end
            `IDX_AMP_TICK_LOW: begin
                read_byte = amp_lead_ticks[7:0];
            end
            `IDX_AMP_SYMBOLS: begin
                read_byte = {3'b000, amp_lead_symbols, amp_lead_ticks[8]};
            end
            `IDX_TX_SYMBOLS: begin
                read_byte = {buffer_path_enable, 1'b0, tx_lead_symbols, tx_lead_ticks[8:7]};
            end
            `IDX_LEAD_STATUS: begin
                // Read-only view of the sequencer
                read_byte = 8'h00;
                read_byte[`STATUS_BUSY_BIT] = lead_busy;
                read_byte[`STATUS_TX_EN_BIT] = tx_enable;
                read_byte[`STATUS_AMP_EN_BIT] = amp_enable;
                read_byte[`STATUS_TRANSMIT_BIT] = (state == ST_TRANSMIT);
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
        if (!aligned) begin
            mapped = 1'b0;
        end
    end

    // Zero-wait slave: answer registered in setup, valid through the access cycle
    // Status is captured at setup, one cycle old at the access edge
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            if (setup) begin
                pslverr <= ~mapped;
                prdata <= (mapped && !pwrite) ? {24'h00_0000, read_byte} : 32'h0000_0000;
            end else begin
                pslverr <= 1'b0;
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Register writes at the completing access edge
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // Power-on defaults
            symbol_tick_count <= `RST_SYMBOL_TICKS;
            tx_lead_ticks <= `RST_TX_LEAD_TICKS;
            tx_lead_symbols <= `RST_TX_LEAD_SYMBOLS;
            amp_lead_ticks <= `RST_AMP_LEAD_TICKS;
            amp_lead_symbols <= `RST_AMP_LEAD_SYMBOLS;
            buffer_path_enable <= `RST_BUFFER_PATH_ENABLE;
        end else if (wr && aligned) begin
            case (idx)
                `IDX_SYMBOL_TICK_LOW: begin
                    symbol_tick_count[7:0] <= pwdata[7:0];
                end
                `IDX_SYMBOL_TICK_HIGH: begin
                    symbol_tick_count[8] <= pwdata[`SYMBOL_TICK_MSB_BIT];
                    tx_lead_ticks[6:0] <= pwdata[`TX_LEAD_LOW_MSB:`TX_LEAD_LOW_LSB];
                end
                `IDX_AMP_TICK_LOW: begin
                    amp_lead_ticks[7:0] <= pwdata[7:0];
                end
                `IDX_AMP_SYMBOLS: begin
                    // Bits 7:5 are not stored, so a stray one is harmless
                    amp_lead_ticks[8] <= pwdata[`AMP_TICK_MSB_BIT];
                    amp_lead_symbols <= pwdata[`AMP_SYMBOLS_MSB:`AMP_SYMBOLS_LSB];
                end
                `IDX_TX_SYMBOLS: begin
                    tx_lead_ticks[8:7] <= pwdata[`TX_TICK_HIGH_MSB:`TX_TICK_HIGH_LSB];
                    tx_lead_symbols <= pwdata[`TX_SYMBOLS_MSB:`TX_SYMBOLS_LSB];
                    buffer_path_enable <= pwdata[`BUFFER_PATH_BIT];
                end
                default: begin
                    // Status and unmapped words: write dropped
                    symbol_tick_count <= symbol_tick_count;
                end
            endcase
        end
    end

    // Lead sequencer: count down the longer lead in ticks to the packet start
    always @* begin
        next_state = state;
        next_remaining = remaining;
        next_packet_start = 1'b0;
        case (state)
            ST_IDLE: begin
                // Requests while the buffer path is off are dropped
                // Lead config is live; change it only while idle
                if (tx_request && buffer_path_enable) begin
                    next_remaining = max_lead;
                    next_state = ST_LEAD;
                end
            end
            ST_LEAD: begin
                if (remaining == {CNT_W{1'b0}}) begin
                    // A zero lead still gives a one-cycle start pulse
                    next_packet_start = 1'b1;
                    next_state = ST_TRANSMIT;
                end else if (tick) begin
                    // One count per 50 ns tick
                    next_remaining = remaining - {{(CNT_W-1){1'b0}}, 1'b1};
                    if (remaining == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                        next_packet_start = 1'b1;
                        next_state = ST_TRANSMIT;
                    end
                end
            end
            ST_TRANSMIT: begin
                // Enables hold until the far side reports completion
                if (tx_done) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_remaining = {CNT_W{1'b0}};
            end
        endcase
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            remaining <= {CNT_W{1'b0}};
            packet_start <= 1'b0;
            lead_busy <= 1'b0;
        end else begin
            state <= next_state;
            remaining <= next_remaining;
            packet_start <= next_packet_start;
            // Busy from the next state, so it rises the cycle after the request
            lead_busy <= (next_state != ST_IDLE);
        end
    end

    // Transmitter enable: symbol lead plus 9-bit tick lead
    lead_compare #(
        .TICK_W(TICK_W),
        .SYM_W(SYM_W),
        .CNT_W(CNT_W)
    ) u_tx_lead (
        .clk(clk),
        .nrst(nrst),
        .active(active),
        .symbol_ticks(symbol_tick_count),
        .lead_symbols(tx_lead_symbols),
        .lead_ticks(tx_lead_ticks),
        .remaining(remaining),
        .lead_total(tx_lead_total),
        .enable(tx_enable)
    );

    // Amplifier enable; a zero symbol lead is not guarded, software keeps it at one or more
    lead_compare #(
        .TICK_W(TICK_W),
        .SYM_W(SYM_W),
        .CNT_W(CNT_W)
    ) u_amp_lead (
        .clk(clk),
        .nrst(nrst),
        .active(active),
        .symbol_ticks(symbol_tick_count),
        .lead_symbols(amp_lead_symbols),
        .lead_ticks(amp_lead_ticks),
        .remaining(remaining),
        .lead_total(amp_lead_total),
        .enable(amp_enable)
    );
endmodule

// ---- include/tx_lead_defines.vh ----
// Register indices, field positions, reset values and timing for the transmit lead timer
`ifndef TX_LEAD_DEFINES_VH
`define TX_LEAD_DEFINES_VH

// Register indices; byte address is four times the index
`define IDX_SYMBOL_TICK_LOW 6'h14
`define IDX_SYMBOL_TICK_HIGH 6'h15
`define IDX_AMP_TICK_LOW 6'h16
`define IDX_AMP_SYMBOLS 6'h17
`define IDX_TX_SYMBOLS 6'h18
`define IDX_LEAD_STATUS 6'h19

// Reset values of the register bytes
`define RST_SYMBOL_TICK_LOW 8'h40
`define RST_SYMBOL_TICK_HIGH 8'h51
`define RST_AMP_TICK_LOW 8'h29
`define RST_AMP_SYMBOLS 8'h02
`define RST_TX_SYMBOLS 8'h88

// Field reset values
`define RST_SYMBOL_TICKS 9'h140
`define RST_TX_LEAD_TICKS 9'h028
`define RST_AMP_LEAD_TICKS 9'h029
`define RST_AMP_LEAD_SYMBOLS 4'h1
`define RST_TX_LEAD_SYMBOLS 4'h2
`define RST_BUFFER_PATH_ENABLE 1'b1

// Field positions
`define SYMBOL_TICK_MSB_BIT 0
`define TX_LEAD_LOW_LSB 1
`define TX_LEAD_LOW_MSB 7
`define AMP_TICK_MSB_BIT 0
`define AMP_SYMBOLS_LSB 1
`define AMP_SYMBOLS_MSB 4
`define TX_TICK_HIGH_LSB 0
`define TX_TICK_HIGH_MSB 1
`define TX_SYMBOLS_LSB 2
`define TX_SYMBOLS_MSB 5
`define BUFFER_PATH_BIT 7

// Status bits
`define STATUS_BUSY_BIT 0
`define STATUS_TX_EN_BIT 1
`define STATUS_AMP_EN_BIT 2
`define STATUS_TRANSMIT_BIT 3

// Timing
`define CLK_PERIOD_NS 20
`define TICK_NS 50
`define PHASE_UNIT_NS 10

`endif

// ---- hdl/lead_compare.v ----
// One enable whose lead before packet start is symbols times symbol period plus ticks
`timescale 1ns/10ps
module lead_compare #(
    parameter TICK_W = 9,
    parameter SYM_W = 4,
    parameter CNT_W = 14
) (
    input wire clk,
    input wire nrst,
    input wire active,
    input wire [TICK_W-1:0] symbol_ticks,
    input wire [SYM_W-1:0] lead_symbols,
    input wire [TICK_W-1:0] lead_ticks,
    input wire [CNT_W-1:0] remaining,
    output wire [CNT_W-1:0] lead_total,
    output reg enable
);
    wire [CNT_W-1:0] symbol_part;

    // Whole symbols of the programmed period, then the extra ticks
    assign symbol_part = {{(CNT_W-TICK_W){1'b0}}, symbol_ticks} * {{(CNT_W-SYM_W){1'b0}}, lead_symbols};
    assign lead_total = symbol_part + {{(CNT_W-TICK_W){1'b0}}, lead_ticks};

    // Rises once the lead remains, then holds until the sequence ends
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            enable <= 1'b0;
        end else begin
            enable <= active & (enable | (remaining <= lead_total));
        end
    end
endmodule

// ---- verification/tx_lead_timer_monitor.sv ----
// Checker for the transmit lead timer ports
`timescale 1ns/10ps
module tx_lead_timer_monitor #(
    parameter ADDR_W = 8
) (
    input wire clk,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire tx_request,
    input wire tx_done,
    input wire tx_enable,
    input wire amp_enable,
    input wire packet_start,
    input wire lead_busy
);
    wire bad_addr = paddr[1:0] != 2'b00 || paddr[ADDR_W-1:2] < 6'h14 || paddr[ADDR_W-1:2] > 6'h19;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable && pready; endsequence
    sequence s_end; ##1 !lead_busy ##1 (!tx_enable && !amp_enable); endsequence
    property p_ready_after_setup; s_setup |=> s_access; endproperty
    property p_ready_pulse; pready |=> !pready; endproperty
    property p_err_unmapped; s_setup and bad_addr |=> pslverr && pready; endproperty
    property p_no_err_mapped; s_setup and !bad_addr |=> !pslverr; endproperty
    property p_busy_rise; tx_request && !lead_busy |=> lead_busy; endproperty
    property p_start_enables; packet_start |-> tx_enable && amp_enable; endproperty
    property p_start_pulse; packet_start |=> !packet_start; endproperty
    property p_tx_fall; $fell(tx_enable) |-> $past(tx_done, 2); endproperty
    property p_amp_fall; $fell(amp_enable) |-> $past(tx_done, 2); endproperty
    property p_done_ends; tx_done && lead_busy |-> s_end; endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("no single-cycle ready");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
    a_err_unmapped: assert property (p_err_unmapped) else $error("missing slave error");
    a_no_err_mapped: assert property (p_no_err_mapped) else $error("spurious slave error");
    a_busy_rise: assert property (p_busy_rise) else $error("request not taken");
    a_start_enables: assert property (p_start_enables) else $error("enable low at packet start");
    a_start_pulse: assert property (p_start_pulse) else $error("packet start too long");
    a_tx_fall: assert property (p_tx_fall) else $error("tx enable fell early");
    a_amp_fall: assert property (p_amp_fall) else $error("amp enable fell early");
    a_done_ends: assert property (p_done_ends) else $error("completion not honoured");
endmodule

// ---- verification/rf_front_end_model.sv ----
// Front end model: reports transmission done after a set delay
`timescale 1ns/10ps
module rf_front_end_model (
    input wire clk,
    input wire nrst,
    input wire [7:0] done_delay,
    input wire packet_start,
    output reg tx_done
);
    integer cnt;
    // Done is only reported after a packet start, never during the lead phase
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_done <= 1'b0;
            cnt <= -1;
        end else begin
            tx_done <= (cnt == 0);
            if (packet_start) begin
                cnt <= done_delay;
            end else if (cnt >= 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

// ---- verification/tb_tx_lead_timer.sv ----
// Testbench for the transmit lead timer
`timescale 1ns/10ps
`include "tx_lead_defines.vh"
module tb_tx_lead_timer;
    reg clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, tx_request = 0;
    reg [7:0] paddr = 8'h00, done_delay = 8'h01;
    reg [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready, pslverr, tx_done, tx_enable, amp_enable, packet_start, lead_busy;
    integer fail_count = 0, n_tests = 0, i;
    reg [31:0] rd;
    reg er;
    reg [7:0] rst_val [0:5];
    always #10 clk = ~clk;
    tx_lead_timer i_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_request(tx_request), .tx_done(tx_done), .tx_enable(tx_enable), .amp_enable(amp_enable),
        .packet_start(packet_start), .lead_busy(lead_busy));
    rf_front_end_model i_fe (.clk(clk), .nrst(nrst), .done_delay(done_delay), .packet_start(packet_start),
        .tx_done(tx_done));
    task check(input [32:0] got, input [32:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task check_near(input integer got, input integer exp);
        n_tests++;
        if (got < exp - 4 || got > exp + 4) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input wr, input [7:0] a, input [31:0] wd);
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge clk);
        penable <= 1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    // Times a lead sequence in clocks from the request edge
    task seq(input integer amp_exp, input integer start_exp);
        integer n, ta, tt;
        @(posedge clk) tx_request <= 1;
        @(posedge clk) tx_request <= 0;
        n = 1; ta = -1; tt = -1;
        while (packet_start !== 1'b1) begin
            @(posedge clk);
            n++;
            if (amp_enable === 1'b1 && ta < 0) ta = n;
            if (tx_enable === 1'b1 && tt < 0) tt = n;
        end
        check(tt, 3);
        check_near(ta, amp_exp);
        check_near(n, start_exp);
        check({tx_enable, amp_enable}, 2'b11);
        while (lead_busy !== 1'b0) begin
            @(posedge clk);
        end
        repeat (2) @(posedge clk);
        check({tx_enable, amp_enable, lead_busy}, 3'b000);
        $display("lead sequence done");
    endtask
    task end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #(20 * 20000);
        fail_count++;
        end_sim;
    end
    initial begin
        rst_val[0] = `RST_SYMBOL_TICK_LOW; rst_val[1] = `RST_SYMBOL_TICK_HIGH; rst_val[2] = `RST_AMP_TICK_LOW;
        rst_val[3] = `RST_AMP_SYMBOLS; rst_val[4] = `RST_TX_SYMBOLS; rst_val[5] = 8'h00;
        repeat (3) @(posedge clk);
        nrst <= 1;
        for (i = 0; i < 6; i++) begin
            apb(0, {`IDX_SYMBOL_TICK_LOW + i[5:0], 2'b00}, 32'h0);
            check({er, rd}, {1'b0, 24'h0, rst_val[i]});
        end
        apb(1, 8'h68, 32'h5a);
        check({er, rd}, {1'b1, 32'h0});
        apb(0, 8'h51, 32'h0);
        check({er, rd}, {1'b1, 32'h0});
        $display("register reset test done");
        // Defaults: tx lead 2*320+40, amp lead 320+41 ticks at 2.5 clocks each
        seq(799, 1700);
        done_delay <= 8'h1e;
        // Symbol 0x100 ticks, tx ticks 0x181, amp ticks 0x105, one symbol each
        apb(1, 8'h50, 32'h00);
        apb(1, 8'h54, 32'h03);
        apb(1, 8'h58, 32'h05);
        apb(1, 8'h5c, 32'h03);
        apb(1, 8'h60, 32'h87);
        apb(0, 8'h5c, 32'h0);
        check(rd, 32'h03);
        apb(0, 8'h60, 32'h0);
        check(rd, 32'h87);
        seq(311, 1603);
        end_sim;
    end
endmodule
bind tx_lead_timer tx_lead_timer_monitor #(.ADDR_W(ADDR_W)) i_mon (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_request(tx_request), .tx_done(tx_done), .tx_enable(tx_enable),
    .amp_enable(amp_enable), .packet_start(packet_start), .lead_busy(lead_busy));
